// ===== hw/port_b_timer_pin_select.sv
`timescale 1ns/10ps
// Notes on behaviour
// - pin 1 carries ch3 B compare when selected
// - otherwise pin 1 is a plain port pin
// - unclaimed pin follows its direction bit
// - pin 1 feeds ch3 B capture when enabled
// - pin 0 carries ch3 A compare when selected
// - otherwise pin 0 keeps port function
// - pin 0 feeds ch3 A capture when enabled
// - pin 2 feeds ch4 A capture when enabled
// - pin 2 carries ch4 A compare when selected
// - port read: latch if output, pin if input
// - direction reg write-only, reads ones, holds when not written
module port_b_timer_pin_select
  import port_pin_sel_pkg::*;
(
  input  wire logic     clk,
  input  wire logic     arst_n,
  input  wire logic     combination_mode_bit,
  input  wire logic     ch3_pwm_mode,
  input  wire logic     ch4_pwm_mode,
  input  wire logic     ch3_a_output_enable,
  input  wire logic     ch3_b_output_enable,
  input  wire logic     ch4_a_output_enable,
  input  wire io_ctl_t  ch3_a_io_control,
  input  wire io_ctl_t  ch3_b_io_control,
  input  wire io_ctl_t  ch4_a_io_control,
  input  wire logic     ch3_compare_a,
  input  wire logic     ch3_compare_b,
  input  wire logic     ch4_compare_a,
  input  wire logic     dir_write,
  input  wire pin_vec_t dir_wdata,
  input  wire logic     latch_write,
  input  wire pin_vec_t latch_wdata,
  output pin_vec_t      dir_rdata,
  output pin_vec_t      port_rdata,
  input  wire pin_vec_t pin_in,
  output pin_vec_t      pin_out,
  output pin_vec_t      pin_oe,
  output pin_vec_t      timer_owns_pin,
  output logic          ch3_capture_a,
  output logic          ch3_capture_b,
  output logic          ch4_capture_a
);

  pin_state_t state_ff;
  pin_state_t nxt_state;
  chan_sel_t  [`PIN_COUNT-1:0] sel;
  pin_vec_t   timer_val;
  pin_vec_t   cap_en;

  // compare-output selection shared by all three pins
  function automatic logic out_sel(input logic comb, input chan_sel_t c);
    logic io_out;
    io_out = (c.io_control == `IO_MODE_ONE) ||
             (c.io_control[`IO_CAPTURE_BIT:1] == 2'h1);
    out_sel = c.output_enable &&
              (comb || (c.allow_pwm && c.pwm_mode) || io_out);
  endfunction

  function automatic logic cap_sel(input logic comb, input chan_sel_t c);
    cap_sel = !comb && !c.pwm_mode && c.io_control[`IO_CAPTURE_BIT];
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // pin 1 (B side) has no pwm term in its output selection
  always_comb begin
    sel[0] = '{ch3_a_output_enable, ch3_pwm_mode, ch3_a_io_control, 1'b1};
    sel[1] = '{ch3_b_output_enable, ch3_pwm_mode, ch3_b_io_control, 1'b0};
    sel[2] = '{ch4_a_output_enable, ch4_pwm_mode, ch4_a_io_control, 1'b1};
    timer_val = {ch4_compare_a, ch3_compare_b, ch3_compare_a};
  end

  genvar g;
  generate
    for (g = 0; g < `PIN_COUNT; g++) begin : g_pin
      always_comb begin
        timer_owns_pin[g] = out_sel(combination_mode_bit, sel[g]);
        cap_en[g] = cap_sel(combination_mode_bit, sel[g]);
        if (timer_owns_pin[g]) begin
          pin_oe[g]  = 1'b1;
          pin_out[g] = timer_val[g];
        end else begin
          pin_oe[g]  = state_ff.port_direction_reg[g];
          pin_out[g] = state_ff.port_output_latch[g];
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // capture sees the synchronised pin level even while an output
  always_comb begin
    ch3_capture_a = cap_en[0] & state_ff.pin_sync2[0];
    ch3_capture_b = cap_en[1] & state_ff.pin_sync2[1];
    ch4_capture_a = cap_en[2] & state_ff.pin_sync2[2];
    dir_rdata = `DIR_READ_VALUE;
    port_rdata = (state_ff.port_direction_reg & state_ff.port_output_latch) |
                 (~state_ff.port_direction_reg & state_ff.pin_sync2);
  end

  ////////////////////////////////////////////////////////////////////////
  // no standby input: direction and latch registers simply hold when not written
  always_comb begin
    nxt_state = state_ff;
    nxt_state.pin_sync1 = pin_in;
    nxt_state.pin_sync2 = state_ff.pin_sync1;
    if (dir_write) begin
      nxt_state.port_direction_reg = dir_wdata;
    end
    if (latch_write) begin
      nxt_state.port_output_latch = latch_wdata;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_ff <= '{`DIR_RESET, `LATCH_RESET, 3'h0, 3'h0};
    end else begin
      state_ff <= nxt_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  dir_reads_ones_a: assert property (@(posedge clk) disable iff (!arst_n)
    dir_rdata == `DIR_READ_VALUE) else $error("dir read not ones");

  dir_write_a: assert property (@(posedge clk) disable iff (!arst_n)
    dir_write |=> state_ff.port_direction_reg == $past(dir_wdata))
    else $error("dir write lost");

  pin1_owner_a: assert property (@(posedge clk) disable iff (!arst_n)
    ch3_b_output_enable && combination_mode_bit |-> timer_owns_pin[1] &&
    pin_out[1] == ch3_compare_b) else $error("pin1 not timer");

  pin1_port_a: assert property (@(posedge clk) disable iff (!arst_n)
    !ch3_b_output_enable |-> !timer_owns_pin[1] &&
    pin_oe[1] == state_ff.port_direction_reg[1])
    else $error("pin1 not port");

  pin0_pwm_a: assert property (@(posedge clk) disable iff (!arst_n)
    ch3_a_output_enable && ch3_pwm_mode |-> pin_oe[0] &&
    pin_out[0] == ch3_compare_a) else $error("pin0 pwm out");

  pin0_port_a: assert property (@(posedge clk) disable iff (!arst_n)
    !ch3_a_output_enable |-> pin_out[0] == state_ff.port_output_latch[0])
    else $error("pin0 not latch");

  pin2_owner_a: assert property (@(posedge clk) disable iff (!arst_n)
    ch4_a_output_enable && ch4_pwm_mode |-> timer_owns_pin[2])
    else $error("pin2 not timer");

  // capture enable must hold over the whole sync delay, not just its start
  sequence b3_cap_held;
    (!combination_mode_bit && !ch3_pwm_mode &&
     ch3_b_io_control[`IO_CAPTURE_BIT] && pin_in[1]) [*3];
  endsequence

  sequence a3_cap_held;
    (!combination_mode_bit && !ch3_pwm_mode &&
     ch3_a_io_control[`IO_CAPTURE_BIT] && pin_in[0]) [*3];
  endsequence

  sequence a4_cap_held;
    (!combination_mode_bit && !ch4_pwm_mode &&
     ch4_a_io_control[`IO_CAPTURE_BIT] && pin_in[2]) [*3];
  endsequence

  cap_b3_a: assert property (@(posedge clk) disable iff (!arst_n)
    b3_cap_held |-> ch3_capture_b)
    else $error("ch3 b capture");

  cap_a3_on_a: assert property (@(posedge clk) disable iff (!arst_n)
    a3_cap_held |-> ch3_capture_a)
    else $error("ch3 a capture");

  cap_a4_on_a: assert property (@(posedge clk) disable iff (!arst_n)
    a4_cap_held |-> ch4_capture_a)
    else $error("ch4 a capture");

  cap_b3_off_a: assert property (@(posedge clk) disable iff (!arst_n)
    !ch3_b_io_control[`IO_CAPTURE_BIT] |-> !ch3_capture_b)
    else $error("ch3 b capture off");

  cap_a3_off_a: assert property (@(posedge clk) disable iff (!arst_n)
    !ch3_a_io_control[`IO_CAPTURE_BIT] |-> !ch3_capture_a)
    else $error("ch3 a capture off");

  pin1_io_a: assert property (@(posedge clk) disable iff (!arst_n)
    ch3_b_output_enable && ch3_b_io_control == `IO_MODE_ONE
    |-> timer_owns_pin[1]) else $error("pin1 io out");

  pin1_free_a: assert property (@(posedge clk) disable iff (!arst_n)
    !combination_mode_bit && ch3_b_io_control == `IO_MODE_OFF
    |-> !timer_owns_pin[1]) else $error("pin1 io off");

  pin0_free_a: assert property (@(posedge clk) disable iff (!arst_n)
    !combination_mode_bit && !ch3_pwm_mode &&
    ch3_a_io_control[`IO_CAPTURE_BIT] |-> !timer_owns_pin[0])
    else $error("pin0 io off");

  latch_write_a: assert property (@(posedge clk) disable iff (!arst_n)
    latch_write |=> state_ff.port_output_latch == $past(latch_wdata))
    else $error("latch write lost");

  read_pin_a: assert property (@(posedge clk) disable iff (!arst_n)
    !state_ff.port_direction_reg[1] |->
    port_rdata[1] == state_ff.pin_sync2[1])
    else $error("read pin level");

  owned_oe_a: assert property (@(posedge clk) disable iff (!arst_n)
    (timer_owns_pin & ~pin_oe) == `IO_MODE_OFF)
    else $error("owned pin not driven");

  cap_a3_a: assert property (@(posedge clk) disable iff (!arst_n)
    combination_mode_bit |-> !ch3_capture_a && !ch4_capture_a)
    else $error("capture in comb");

  cap_a4_a: assert property (@(posedge clk) disable iff (!arst_n)
    ch4_pwm_mode |-> !ch4_capture_a) else $error("ch4 cap pwm");

  read_back_a: assert property (@(posedge clk) disable iff (!arst_n)
    state_ff.port_direction_reg[0] |-> port_rdata[0] ==
    state_ff.port_output_latch[0]) else $error("read latch");

  free_pin_a: assert property (@(posedge clk) disable iff (!arst_n)
    !timer_owns_pin[2] |-> pin_oe[2] == state_ff.port_direction_reg[2])
    else $error("free pin dir");

  owned_val_a: assert property (@(posedge clk) disable iff (!arst_n)
    timer_owns_pin[2] |-> pin_out[2] == ch4_compare_a)
    else $error("owned value");

endmodule

// ===== hw/port_pin_sel_cfg.svh
`ifndef PORT_PIN_SEL_CFG_SVH
`define PORT_PIN_SEL_CFG_SVH

`define PIN_COUNT        3
`define IO_CTL_W         3
`define IO_CAPTURE_BIT   2
`define IO_MODE_OFF      3'h0
`define IO_MODE_ONE      3'h1
`define DIR_RESET        3'h0
`define LATCH_RESET      3'h0
`define DIR_READ_VALUE   3'h7

`endif

// ===== hw/port_pin_sel_pkg.sv
package port_pin_sel_pkg;

  `include "port_pin_sel_cfg.svh"

  typedef logic [`PIN_COUNT-1:0] pin_vec_t;
  typedef logic [`IO_CTL_W-1:0]  io_ctl_t;

  // timer settings that steer one shared pin
  typedef struct packed {
    logic    output_enable;
    logic    pwm_mode;
    io_ctl_t io_control;
    logic    allow_pwm;
  } chan_sel_t;

  // all state of the block
  typedef struct packed {
    pin_vec_t port_direction_reg;
    pin_vec_t port_output_latch;
    pin_vec_t pin_sync1;
    pin_vec_t pin_sync2;
  } pin_state_t;

endpackage

// ===== tb/pin_board.sv
`timescale 1ns/10ps
module pin_board
  import port_pin_sel_pkg::*;
(
  input  wire pin_vec_t  pin_out,
  input  wire pin_vec_t  pin_oe,
  input  wire pin_vec_t  ext_level,
  output pin_vec_t       pin_in
);
  // a driven pin reads back its driver, an idle one the board level
  always_comb pin_in = (pin_out & pin_oe) | (ext_level & ~pin_oe);
endmodule

// ===== tb/port_b_timer_pin_select_bench.sv
`timescale 1ns/10ps
module port_b_timer_pin_select_bench
  import port_pin_sel_pkg::*;
;
  logic       clk = 1'b0;
  logic       arst_n = 1'b0;
  logic [5:0] mode = 6'h00;
  io_ctl_t    ioc = 3'h0;
  pin_vec_t   cmp = 3'h6;
  pin_vec_t   ext = 3'h7;
  logic       dir_write = 1'b0;
  logic       latch_write = 1'b0;
  pin_vec_t   dir_wdata = 3'h0;
  pin_vec_t   latch_wdata = 3'h0;
  pin_vec_t   dir_rdata, port_rdata, pin_in, pin_out, pin_oe, timer_owns_pin;
  logic       ch3_capture_a, ch3_capture_b, ch4_capture_a;
  pin_vec_t   caps;
  int         n_mismatch = 0;
  int         checked = 0;
  int         cycles = 0;

  always #10 clk = ~clk;
  assign caps = {ch4_capture_a, ch3_capture_b, ch3_capture_a};

  port_b_timer_pin_select uut (
    .combination_mode_bit(mode[5]), .ch3_pwm_mode(mode[4]),
    .ch4_pwm_mode(mode[3]), .ch3_a_output_enable(mode[2]),
    .ch3_b_output_enable(mode[1]), .ch4_a_output_enable(mode[0]),
    .ch3_a_io_control(ioc), .ch3_b_io_control(ioc), .ch4_a_io_control(ioc),
    .ch3_compare_a(cmp[0]), .ch3_compare_b(cmp[1]), .ch4_compare_a(cmp[2]),
    .*);
  pin_board board (.pin_out, .pin_oe, .ext_level(ext), .pin_in);

  ////////////////////////////////////////////////////////////////////////////
  task step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task chk(input pin_vec_t got, input pin_vec_t exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // three cycles cover the two-flop pin sync
  task cfg(input logic [5:0] m, input io_ctl_t i);
    @(posedge clk);
    mode <= m;
    ioc <= i;
    step(3);
  endtask

  task wr(input pin_vec_t d, input pin_vec_t l);
    @(posedge clk);
    dir_write <= 1'b1;
    latch_write <= 1'b1;
    dir_wdata <= d;
    latch_wdata <= l;
    @(posedge clk);
    dir_write <= 1'b0;
    latch_write <= 1'b0;
    step(3);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task t_port;
    wr(3'h5, 3'h1);
    chk(pin_oe, 3'h5);
    chk(pin_out & pin_oe, 3'h1);
    chk(port_rdata, 3'h3);
    chk(dir_rdata, 3'h7);
  endtask

  // latch bit 0 set so a leak past the timer value shows on pin 0
  task t_codes;
    wr(3'h0, 3'h1);
    for (int i = 0; i < 8; i++) begin
      cfg(6'h07, i[2:0]);
      chk(timer_owns_pin, (i inside {[1:3]}) ? 3'h7 : 3'h0);
      chk(pin_out & pin_oe, (i inside {[1:3]}) ? 3'h6 : 3'h0);
      chk(caps, i[2] ? 3'h7 : 3'h0);
    end
  endtask

  task t_modes;
    cfg(6'h27, 3'h4);
    chk(timer_owns_pin, 3'h7);
    chk(caps, 3'h0);
    cfg(6'h1F, 3'h4);
    chk(timer_owns_pin, 3'h5);
    chk(caps, 3'h0);
    cfg(6'h38, 3'h1);
    chk(timer_owns_pin, 3'h0);
    chk(pin_oe, 3'h0);
  endtask

  task summarize;
    if (n_mismatch == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 1000) begin
      n_mismatch++;
      summarize();
    end
  end

  initial begin
    repeat (5) @(posedge clk);
    arst_n <= 1'b1;
    step(3);
    chk(dir_rdata, 3'h7);
    chk(pin_oe, 3'h0);
    chk(port_rdata, 3'h7);
    t_port();
    t_codes();
    t_modes();
    summarize();
  end
endmodule
